// [verilog/frm_defines.vh]
/*
 * Constants of the fault response manager: timing figures and their
 * cycle counts, register offsets, field positions and reset values.
 * Assumes a single 25 MHz system clock.
 */
`ifndef FRM_DEFINES_VH
`define FRM_DEFINES_VH

// System clock rate
`define FRM_CLK_HZ 25000000

// Input overvoltage qualification, least time, rounded up
`define FRM_INPUT_OVERVOLTAGE_FAULT_QUAL_NS 5000
`define FRM_INPUT_OVERVOLTAGE_FAULT_QUAL_CYC \
	((`FRM_CLK_HZ / 1000000 * `FRM_INPUT_OVERVOLTAGE_FAULT_QUAL_NS + 999) / 1000)

// Automatic restart wait
`define FRM_HICCUP_MS 500
`define FRM_HICCUP_CYC (`FRM_CLK_HZ / 1000 * `FRM_HICCUP_MS)

// Power-good release delay
`define FRM_PG_DELAY_US 500
`define FRM_PG_DELAY_CYC (`FRM_CLK_HZ / 1000000 * `FRM_PG_DELAY_US)

// Minimum switching frequency, longest period rounded down
`define FRM_MIN_FREQ_HZ 37000
`define FRM_LOCK_CYC (`FRM_CLK_HZ / `FRM_MIN_FREQ_HZ)

// Consecutive switching cycles for peak overcurrent
`define FRM_PEAK_CYCLES 3

// Register offsets
`define FRM_ADDR_CTRL 4'h0
`define FRM_ADDR_STATUS 4'h1
`define FRM_ADDR_EVENT 4'h2
`define FRM_ADDR_MASK 4'h3

// Reset values
`define FRM_CTRL_RESET 8'h01
`define FRM_MASK_RESET 8'h00

// Control fields
`define FRM_CTRL_LOCK_EN 0

// Event and mask fields
`define FRM_EV_INPUT_OV 0
`define FRM_EV_AVG_OC 1
`define FRM_EV_PEAK_OC 2
`define FRM_EV_OUTPUT_OV 3
`define FRM_EV_LOOP_SHORT 4
`define FRM_EV_LOCK_LOSS 5
`define FRM_EV_UV_SET 6
`define FRM_EV_PG_RISE 7

`endif

// [verilog/frm_hold_timer.v]
/*
 * Hold timer: counts clock cycles while its hold input stays high and
 * reports done once the count reaches the terminal value.
 * Assumes a synchronous active-low reset.
 */
module frm_hold_timer #(
	parameter W = 24,
	parameter LIMIT = 125
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Control
	input wire hold,
	output wire done
);

localparam [W-1:0] LIM = LIMIT[W-1:0];
localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

reg [W-1:0] cnt_reg;

////////////////////////////////////////////////////////////////////////
// Counter restarts whenever hold drops
always @(posedge clk) begin
	if (!rst_b) begin
		cnt_reg <= {W{1'b0}};
	end else if (!hold) begin
		cnt_reg <= {W{1'b0}};
	end else if (cnt_reg != LIM) begin
		cnt_reg <= cnt_reg + ONE;
	end
end

assign done = hold && (cnt_reg == LIM);

endmodule // frm_hold_timer

// [verilog/frm_peak_qual.v]
/*
 * Peak overcurrent qualifier: per phase, counts switching cycles in
 * which the current-sense comparator tripped, back to back.
 * Assumes one cycle pulse per switching period.
 */
module frm_peak_qual #(
	parameter PHASES = 2,
	parameter CONSEC = 3,
	parameter CW = 2
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Inputs
	input wire arm,
	input wire cycle,
	input wire [PHASES-1:0] trip,
	// Result
	output wire fault
);

localparam [CW-1:0] LIM = CONSEC[CW-1:0];
localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

wire [PHASES-1:0] hit;

////////////////////////////////////////////////////////////////////////
// One counter per phase
genvar g;
generate
	for (g = 0; g < PHASES; g = g + 1) begin : g_phase
		reg seen_reg;
		reg [CW-1:0] cnt_reg;
		always @(posedge clk) begin
			if (!rst_b || !arm) begin
				seen_reg <= 1'b0;
				cnt_reg <= {CW{1'b0}};
			end else if (cycle) begin
				seen_reg <= 1'b0;
				if (seen_reg || trip[g]) begin
					if (cnt_reg != LIM)
						cnt_reg <= cnt_reg + ONE;
				end else begin
					cnt_reg <= {CW{1'b0}};
				end
			end else if (trip[g]) begin
				seen_reg <= 1'b1;
			end
		end
		assign hit[g] = (cnt_reg == LIM);
	end
endgenerate

assign fault = arm && (|hit);

endmodule // frm_peak_qual

// [verilog/frm_fault_manager.v]
/*
 * Fault response manager top: qualifies fault flags, runs the restart
 * or latched shutdown response, times power-good, and offers a small
 * register port with sticky events, mask and one interrupt.
 * Assumes comparator flags and straps synchronous to CLK_SYS.
 */
// Added by the designer: the address-and-strobe port and the register addresses.
//
// Function
// - Select high: automatic restart for all faults
// - Select low: latched shutdown for all faults
// - Restart: stop, wait 500ms, soft-start again
// - Latched: stay off, driver supply stays on
// - Latch left only by enable toggle or reset
// - Response covers the six selectable faults
// - Input overvoltage after 5us; power-good low
// - Overvoltage detection armed at soft-start begin
// - Fault stops switching, enters response same cycle
// - Power-good rises 0.5ms after conditions clear
// - Feedback above 120% is output overvoltage
// - Overvoltage restart needs feedback 4% below trip
// - Feedback below 80% flags undervoltage
// - Undervoltage never stops switching
// - Undervoltage clears above 80% plus 4%
// - Below 37kHz switching is loss of lock
// - Peak overcurrent needs three consecutive cycles
`include "frm_defines.vh"

module frm_fault_manager #(
	parameter HICCUP_CYC = `FRM_HICCUP_CYC,
	parameter PG_DELAY_CYC = `FRM_PG_DELAY_CYC,
	parameter INPUT_OVERVOLTAGE_FAULT_QUAL_CYC = `FRM_INPUT_OVERVOLTAGE_FAULT_QUAL_CYC,
	parameter LOCK_CYC = `FRM_LOCK_CYC,
	parameter PHASES = 2
) (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST_B,
	// Enable and strap
	input wire EN,
	input wire FAULT_RESPONSE_SELECT,
	// Comparator flags
	input wire INPUT_OV_CMP,
	input wire FEEDBACK_OV_TRIP,
	input wire FEEDBACK_OV_CLEAR,
	input wire FEEDBACK_UV_TRIP,
	input wire FEEDBACK_UV_CLEAR,
	input wire AVG_OC_CMP,
	input wire [PHASES-1:0] PEAK_OC_CMP,
	input wire LOOP_FILTER_SHORT_CMP,
	input wire SW_CYCLE,
	// Power stage control
	output wire SWITCH_EN,
	output wire SOFT_START,
	output wire DRIVER_SUPPLY_EN,
	output wire POWER_GOOD_OUT,
	// Register port
	input wire [3:0] ADDR,
	input wire [7:0] WR_DATA,
	input wire WR_STB,
	input wire RD_STB,
	output wire [7:0] RD_DATA,
	output wire IRQ
);

////////////////////////////////////////////////////////////////////////
// States

localparam [3:0] ST_OFF = 4'h1;
localparam [3:0] ST_RUN = 4'h2;
localparam [3:0] ST_WAIT = 4'h4;
localparam [3:0] ST_LATCH = 4'h8;

////////////////////////////////////////////////////////////////////////
// Declarations

reg [3:0] state_reg;
reg [3:0] state_next;
reg switch_en_reg;
reg soft_start_reg;
reg driver_supply_reg;
reg power_good_reg;
reg power_good_next;
reg out_ov_pending_reg;
reg uv_flag_reg;
reg [7:0] ctrl_reg;
reg [7:0] event_reg;
reg [7:0] event_next;
reg [7:0] mask_reg;
reg [7:0] rd_data_reg;
reg [7:0] rd_data_next;
reg irq_reg;

wire armed;
wire lock_en;
wire input_overvoltage_fault;
wire output_overvoltage_fault;
wire average_overcurrent_fault;
wire peak_overcurrent_fault;
wire loop_filter_short_fault;
wire lock_loss_fault;
wire [5:0] fault_vec;
wire fault_any;
wire hiccup_done;
wire pg_ok;
wire pg_done;
wire uv_set_event;
wire [7:0] event_set;
wire [7:0] status_word;

////////////////////////////////////////////////////////////////////////
// Detection arming

// Detectors run from the first cycle of soft-start onward
assign armed = (state_reg == ST_RUN);
assign lock_en = ctrl_reg[`FRM_CTRL_LOCK_EN];

////////////////////////////////////////////////////////////////////////
// Fault qualification

// Input overvoltage must persist for the qualification time
frm_hold_timer #(
	.W(12),
	.LIMIT(INPUT_OVERVOLTAGE_FAULT_QUAL_CYC)
) u_input_overvoltage_fault_timer (
	.clk(CLK_SYS),
	.rst_b(RST_B),
	.hold(armed && INPUT_OV_CMP),
	.done(input_overvoltage_fault)
);

// No switching edge within the longest period
frm_hold_timer #(
	.W(12),
	.LIMIT(LOCK_CYC)
) u_lock_timer (
	.clk(CLK_SYS),
	.rst_b(RST_B),
	.hold(armed && lock_en && !SW_CYCLE),
	.done(lock_loss_fault)
);

// Per-phase peak qualification
frm_peak_qual #(
	.PHASES(PHASES),
	.CONSEC(`FRM_PEAK_CYCLES),
	.CW(2)
) u_peak_qual (
	.clk(CLK_SYS),
	.rst_b(RST_B),
	.arm(armed),
	.cycle(SW_CYCLE),
	.trip(PEAK_OC_CMP),
	.fault(peak_overcurrent_fault)
);

assign output_overvoltage_fault = armed && FEEDBACK_OV_TRIP;
assign average_overcurrent_fault = armed && AVG_OC_CMP;
assign loop_filter_short_fault = armed && LOOP_FILTER_SHORT_CMP;

// The six faults that take the selected response
assign fault_vec = {lock_loss_fault,
	loop_filter_short_fault,
	output_overvoltage_fault,
	peak_overcurrent_fault,
	average_overcurrent_fault,
	input_overvoltage_fault};
assign fault_any = |fault_vec;

////////////////////////////////////////////////////////////////////////
// Restart wait

frm_hold_timer #(
	.W(24),
	.LIMIT(HICCUP_CYC)
) u_hiccup_timer (
	.clk(CLK_SYS),
	.rst_b(RST_B),
	.hold(state_reg == ST_WAIT),
	.done(hiccup_done)
);

////////////////////////////////////////////////////////////////////////
// Response state machine

always @* begin
	state_next = state_reg;
	case (state_reg)
	ST_OFF: begin
		if (EN)
			state_next = ST_RUN;
	end
	ST_RUN: begin
		if (fault_any) begin
			if (FAULT_RESPONSE_SELECT)
				state_next = ST_WAIT;
			else
				state_next = ST_LATCH;
		end
	end
	ST_WAIT: begin
		// Retry through soft-start; a lasting fault trips again
		if (hiccup_done && !out_ov_pending_reg)
			state_next = ST_RUN;
	end
	ST_LATCH: begin
		state_next = ST_LATCH;
	end
	default: begin
		state_next = ST_OFF;
	end
	endcase
	// Dropping enable is the only way out of ST_LATCH besides reset
	if (!EN)
		state_next = ST_OFF;
end

always @(posedge CLK_SYS) begin
	if (!RST_B) begin
		state_reg <= ST_OFF;
		switch_en_reg <= 1'b0;
		soft_start_reg <= 1'b0;
		driver_supply_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		switch_en_reg <= (state_next == ST_RUN);
		soft_start_reg <= (state_next == ST_RUN) &&
			(state_reg != ST_RUN);
		driver_supply_reg <= EN;
	end
end

////////////////////////////////////////////////////////////////////////
// Feedback hysteresis flags

always @(posedge CLK_SYS) begin
	if (!RST_B) begin
		out_ov_pending_reg <= 1'b0;
		uv_flag_reg <= 1'b0;
	end else begin
		// Set wins over clear
		if (output_overvoltage_fault)
			out_ov_pending_reg <= 1'b1;
		else if (FEEDBACK_OV_CLEAR)
			out_ov_pending_reg <= 1'b0;
		if (FEEDBACK_UV_TRIP)
			uv_flag_reg <= 1'b1;
		else if (FEEDBACK_UV_CLEAR)
			uv_flag_reg <= 1'b0;
	end
end

// Undervoltage affects power-good, status and its event bit, never the state machine
assign uv_set_event = FEEDBACK_UV_TRIP && !uv_flag_reg;

////////////////////////////////////////////////////////////////////////
// Power-good

assign pg_ok = (state_reg == ST_RUN) && !fault_any &&
	!uv_flag_reg && !out_ov_pending_reg;

frm_hold_timer #(
	.W(16),
	.LIMIT(PG_DELAY_CYC)
) u_pg_timer (
	.clk(CLK_SYS),
	.rst_b(RST_B),
	.hold(pg_ok),
	.done(pg_done)
);

always @* begin
	// Any declared fault or undervoltage pulls it low at once
	power_good_next = pg_ok && pg_done;
end

always @(posedge CLK_SYS) begin
	if (!RST_B)
		power_good_reg <= 1'b0;
	else
		power_good_reg <= power_good_next;
end

////////////////////////////////////////////////////////////////////////
// Events and interrupt

assign event_set = {power_good_next && !power_good_reg,
	uv_set_event,
	fault_vec};

always @* begin
	event_next = event_reg;
	if (WR_STB && (ADDR == `FRM_ADDR_EVENT))
		event_next = event_next & ~WR_DATA;
	// Set wins over a simultaneous clear
	event_next = event_next | event_set;
end

////////////////////////////////////////////////////////////////////////
// Register port

assign status_word = {2'h0,
	FAULT_RESPONSE_SELECT,
	uv_flag_reg,
	power_good_reg,
	state_reg == ST_LATCH,
	state_reg == ST_WAIT,
	state_reg == ST_RUN};

always @* begin
	rd_data_next = 8'h00;
	if (RD_STB) begin
		case (ADDR)
		`FRM_ADDR_CTRL: rd_data_next = ctrl_reg;
		`FRM_ADDR_STATUS: rd_data_next = status_word;
		`FRM_ADDR_EVENT: rd_data_next = event_reg;
		`FRM_ADDR_MASK: rd_data_next = mask_reg;
		default: rd_data_next = 8'h00;
		endcase
	end
end

always @(posedge CLK_SYS) begin
	if (!RST_B) begin
		ctrl_reg <= `FRM_CTRL_RESET;
		mask_reg <= `FRM_MASK_RESET;
		event_reg <= 8'h00;
		rd_data_reg <= 8'h00;
		irq_reg <= 1'b0;
	end else begin
		if (WR_STB && (ADDR == `FRM_ADDR_CTRL))
			ctrl_reg <= WR_DATA;
		if (WR_STB && (ADDR == `FRM_ADDR_MASK))
			mask_reg <= WR_DATA;
		event_reg <= event_next;
		rd_data_reg <= rd_data_next;
		irq_reg <= |(event_next & mask_reg);
	end
end

////////////////////////////////////////////////////////////////////////
// Outputs

assign SWITCH_EN = switch_en_reg;
assign SOFT_START = soft_start_reg;
assign DRIVER_SUPPLY_EN = driver_supply_reg;
assign POWER_GOOD_OUT = power_good_reg;
assign RD_DATA = rd_data_reg;
assign IRQ = irq_reg;

endmodule // frm_fault_manager

// [tb/frm_fault_monitor.sv]
/* Checker of the fault response manager top ports.
   Assumes one clock domain and a synchronous active-low reset. */
module frm_fault_monitor #(
	parameter int HICCUP_CYC = 50,
	parameter int PG_DELAY_CYC = 20
) (
	// Clock and reset
	input logic CLK_SYS,
	input logic RST_B,
	// Inputs
	input logic EN,
	input logic FAULT_RESPONSE_SELECT,
	input logic AVG_OC_CMP,
	input logic LOOP_FILTER_SHORT_CMP,
	input logic FEEDBACK_OV_TRIP,
	input logic FEEDBACK_UV_TRIP,
	// Outputs
	input logic SWITCH_EN,
	input logic SOFT_START,
	input logic DRIVER_SUPPLY_EN,
	input logic POWER_GOOD_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int H_LO = HICCUP_CYC - 2;
	logic latched_reg = 1'b0;
	int on_cnt_reg = 0;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////////////////////////////////
	// Latched state and run length
	always @(posedge CLK_SYS) begin
		if (!RST_B || !EN)
			latched_reg <= 1'b0;
		else if (SWITCH_EN && !FAULT_RESPONSE_SELECT && (AVG_OC_CMP ||
			LOOP_FILTER_SHORT_CMP || FEEDBACK_OV_TRIP))
			latched_reg <= 1'b1;
		if (!RST_B || !SWITCH_EN || FEEDBACK_UV_TRIP || FEEDBACK_OV_TRIP)
			on_cnt_reg <= 0;
		else
			on_cnt_reg <= on_cnt_reg + 1;
	end
	////////////////////////////////////////////////////////////////////
	sequence seq_trip_hic;
		SWITCH_EN && EN && FAULT_RESPONSE_SELECT &&
			(AVG_OC_CMP || LOOP_FILTER_SHORT_CMP);
	endsequence
	sequence seq_wait;
		(!SWITCH_EN) throughout (##[H_LO:H_LO] 1);
	endsequence
	chk_hiccup_wait: assert property (
		seq_trip_hic |=> seq_wait ##[1:4] SWITCH_EN)
		else $error("restart wait wrong");
	chk_fault_stop: assert property (
		SWITCH_EN && (AVG_OC_CMP || LOOP_FILTER_SHORT_CMP) |=>
		!SWITCH_EN && !POWER_GOOD_OUT)
		else $error("fault did not stop switching");
	chk_ov_trip: assert property (
		SWITCH_EN && FEEDBACK_OV_TRIP |=> !SWITCH_EN && !POWER_GOOD_OUT)
		else $error("overvoltage not acted on");
	chk_uv_pg: assert property (
		SWITCH_EN && FEEDBACK_UV_TRIP |-> ##[1:2] !POWER_GOOD_OUT)
		else $error("undervoltage left power good high");
	chk_start_pulse: assert property (
		$rose(SWITCH_EN) |-> SOFT_START)
		else $error("start without soft start");
	chk_pulse_len: assert property (
		SOFT_START |-> SWITCH_EN ##1 !SOFT_START)
		else $error("soft start pulse wrong");
	chk_latch_hold: assert property (
		latched_reg && EN |-> !SWITCH_EN)
		else $error("latched state left");
	chk_drv_supply: assert property (
		latched_reg && $past(EN) |-> DRIVER_SUPPLY_EN)
		else $error("driver supply off while latched");
	chk_pg_delay: assert property (
		$rose(POWER_GOOD_OUT) |-> on_cnt_reg > PG_DELAY_CYC)
		else $error("power good rose too early");
endmodule // frm_fault_monitor

bind frm_fault_manager frm_fault_monitor #(
	.HICCUP_CYC(HICCUP_CYC),
	.PG_DELAY_CYC(PG_DELAY_CYC)
) u_monitor (
	.CLK_SYS(CLK_SYS),
	.RST_B(RST_B),
	.EN(EN),
	.FAULT_RESPONSE_SELECT(FAULT_RESPONSE_SELECT),
	.AVG_OC_CMP(AVG_OC_CMP),
	.LOOP_FILTER_SHORT_CMP(LOOP_FILTER_SHORT_CMP),
	.FEEDBACK_OV_TRIP(FEEDBACK_OV_TRIP),
	.FEEDBACK_UV_TRIP(FEEDBACK_UV_TRIP),
	.SWITCH_EN(SWITCH_EN),
	.SOFT_START(SOFT_START),
	.DRIVER_SUPPLY_EN(DRIVER_SUPPLY_EN),
	.POWER_GOOD_OUT(POWER_GOOD_OUT)
);

// [tb/frm_board_model.sv]
/* Board side: strap pin, enable toggle, power-good rise counter.
   Assumes commands from the bench, one clock. */
module frm_board_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Commands
	input wire logic sel_cmd,
	input wire logic tog_cmd,
	input wire logic pg,
	// Pins and count
	output logic strap = 1'b1,
	output logic en = 1'b1,
	output int pg_rises = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pg_prev_reg = 1'b0;
	always @(posedge clk) begin
		strap <= sel_cmd;
		en <= !tog_cmd;
		pg_prev_reg <= pg;
		if (!rst_b)
			pg_rises <= 0;
		else if (pg && !pg_prev_reg)
			pg_rises <= pg_rises + 1;
	end
endmodule // frm_board_model

// [tb/frm_fault_manager_test.sv]
/* Testbench of the fault response manager with short timer counts.
   Assumes the board model and the bound checker. */
module frm_fault_manager_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HC = 50, PG = 20, VQ = 10, LK = 20;
	logic clk = 0, rst_b = 0, sel_cmd = 1, tog = 0, uv_t = 0, uv_c = 1;
	logic ov_c = 1, wr = 0, rd = 0, sw = 0, ph = 0;
	logic [5:0] f = 0;
	logic [3:0] addr = 0;
	logic [7:0] wd = 0, d;
	wire sw_en, ss, drv, pg, irq, strap, en;
	wire [7:0] rdd;
	int pg_rises, n_mismatch = 0, num_checks = 0, seed = 45465;
	int n, m, np, exp_rise = 0;
	int lo[6], hi[6], eb[6];
	int ev_q[$];
	frm_board_model brd (.clk(clk), .rst_b(rst_b), .sel_cmd(sel_cmd),
		.tog_cmd(tog), .pg(pg), .strap(strap), .en(en),
		.pg_rises(pg_rises));
	frm_fault_manager #(.HICCUP_CYC(HC), .PG_DELAY_CYC(PG),
		.INPUT_OVERVOLTAGE_FAULT_QUAL_CYC(VQ), .LOCK_CYC(LK), .PHASES(2)) uut (
		.CLK_SYS(clk), .RST_B(rst_b), .EN(en),
		.FAULT_RESPONSE_SELECT(strap), .INPUT_OV_CMP(f[3]),
		.FEEDBACK_OV_TRIP(f[2]), .FEEDBACK_OV_CLEAR(ov_c),
		.FEEDBACK_UV_TRIP(uv_t), .FEEDBACK_UV_CLEAR(uv_c),
		.AVG_OC_CMP(f[0]), .PEAK_OC_CMP({f[4] && !ph, f[4] && ph}),
		.LOOP_FILTER_SHORT_CMP(f[1]), .SW_CYCLE(sw), .SWITCH_EN(sw_en),
		.SOFT_START(ss), .DRIVER_SUPPLY_EN(drv), .POWER_GOOD_OUT(pg),
		.ADDR(addr), .WR_DATA(wd), .WR_STB(wr), .RD_STB(rd),
		.RD_DATA(rdd), .IRQ(irq));
	////////////////////////////////////////////////////////////////////
	initial forever #20 clk = ~clk;
	initial forever begin
		repeat (4 + {$random(seed)} % 8) @(posedge clk);
		sw <= !f[5];
		@(posedge clk);
		sw <= 0;
	end
	task tick; @(posedge clk); #1; endtask
	// Expected event word from the queued event bits
	function automatic int ev_drain;
		int e;
		e = 0;
		while (ev_q.size() > 0)
			e = e | (1 << ev_q.pop_front());
		return e;
	endfunction
	task chk(input logic [31:0] v, input logic [31:0] e);
		num_checks++;
		if (v !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask
	task wrt(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk); addr <= a; wd <= v; wr <= 1;
		@(posedge clk); wr <= 0;
	endtask
	task rdt(input logic [3:0] a);
		@(posedge clk); addr <= a; rd <= 1;
		@(posedge clk); rd <= 0;
		#1 d = rdd;
	endtask
	task wait_pg;
		n = 0;
		while (pg !== 1 && n < 500) begin tick; n++; end
		chk(n >= PG && n <= PG + 4, 1);
		exp_rise++;
	endtask
	// Raise one fault source, then time stop and restart
	task hic(input int k, input int ext);
		@(posedge clk); f[k] <= 1; if (k == 2) ov_c <= 0;
		#1 np = sw;
		m = 0;
		do begin tick; m++; np += sw; end while (sw_en === 1 && m < 200);
		f[k] <= 0;
		chk(m >= lo[k] && m <= hi[k], 1);
		if (k == 4) chk(np, 3);
		chk({sw_en, pg}, 2'b00);
		n = 0;
		do begin
			@(posedge clk); if (n == ext) ov_c <= 1; #1; n++;
		end while (sw_en !== 1 && n < 500);
		m = ext > HC ? ext : HC;
		chk(n >= m && n <= m + 4, 1);
		chk(ss, 1);
		wait_pg;
		chk(irq, k == 0);
		ev_q.push_back(eb[k]); ev_q.push_back(7);
		rdt(2); chk(d, ev_drain());
		wrt(2, 8'hFF); tick; chk(irq, 0);
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin repeat (20000) @(posedge clk); n_mismatch++; results; end
	////////////////////////////////////////////////////////////////////
	initial begin
		lo = '{1, 1, 1, VQ + 1, 1, LK - 12};
		hi = '{1, 1, 1, VQ + 2, 60, LK + 3};
		eb = '{1, 4, 3, 0, 2, 5};
		repeat (10) @(posedge clk);
		rst_b <= 1;
		n = 0;
		while (sw_en !== 1 && n < 50) begin tick; n++; end
		wait_pg;
		rdt(0); chk(d, 8'h01);
		rdt(3); chk(d, 8'h00);
		rdt(9); chk(d, 8'h00);
		wrt(3, 8'h02); rdt(3); chk(d, 8'h02);
		@(posedge clk); f[3] <= 1;
		repeat (VQ) @(posedge clk);
		f[3] <= 0; tick; tick; chk(sw_en, 1);
		@(posedge clk); f[4] <= 1; #1 np = sw;
		while (np < 2) begin tick; np += sw; end
		f[4] <= 0; repeat (3) tick; chk(sw_en, 1);
		ph <= 1;
		for (int k = 0; k < 6; k++) hic(k, k == 2 ? HC + 30 : 0);
		@(posedge clk); uv_t <= 1; uv_c <= 0;
		repeat (5) tick; chk({sw_en, pg}, 2'b10);
		uv_t <= 0; repeat (PG + 5) tick; chk(pg, 0);
		uv_c <= 1; wait_pg;
		ev_q.push_back(6); ev_q.push_back(7);
		rdt(2); chk(d, ev_drain());
		wrt(2, 8'hFF);
		@(posedge clk); sel_cmd <= 0; tick; tick;
		@(posedge clk); f[0] <= 1;
		@(posedge clk); f[0] <= 0;
		repeat (3 * HC) tick;
		chk({sw_en, drv}, 2'b01);
		rdt(1); chk(d, 8'h04);
		@(posedge clk); tog <= 1;
		@(posedge clk); tog <= 0;
		n = 0;
		while (sw_en !== 1 && n < 50) begin tick; n++; end
		chk(n < 10, 1);
		wait_pg;
		// Lock detection off: a stalled switching clock is ignored
		wrt(0, 8'h00); @(posedge clk); f[5] <= 1;
		repeat (3 * LK) tick; chk(sw_en, 1);
		f[5] <= 0; wrt(0, 8'h01);
		tick; chk(pg_rises, exp_rise);
		results;
	end
endmodule // frm_fault_manager_test
